// ===== hw/ain_trip_defines.svh
// ain_trip_defines.svh: offsets, reset values, limits, status bit positions, timing counts
// for the analog input scaling and trip block.
// assumes a 12-bit raw input code where 4095 stands for full scale.
`ifndef AIN_TRIP_DEFINES_SVH
`define AIN_TRIP_DEFINES_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define ADDR_TRIP_TYPE   12'h000
`define ADDR_TRIP_LEVEL  12'h004
`define ADDR_TRIP_DELAY  12'h008
`define ADDR_SPAN        12'h00c
`define ADDR_OFFSET      12'h010
`define ADDR_READING     12'h014
`define ADDR_LIVE        12'h018
`define ADDR_INT_STATUS  12'h01c
`define ADDR_INT_CLEAR   12'h020
`define ADDR_INT_ENABLE  12'h024

// -----------------------------------------------------------------
// reset values and limits
// -----------------------------------------------------------------
`define LEVEL_RST        7'd50
`define LEVEL_MAX        7'd100
`define DELAY_RST        10'd1
`define DELAY_MIN        10'd1
`define DELAY_MAX        10'd900
`define SPAN_RST         7'd100
`define SPAN_MIN         7'd1
`define SPAN_MAX         7'd100
`define OFFSET_RST       7'd0
`define OFFSET_MAX       7'd99
`define PCT_FULL         7'd100
`define FS_CODE          12'd4095

// -----------------------------------------------------------------
// status bit positions and timing
// -----------------------------------------------------------------
`define STS_TRIP         0
`define STS_ONSET        1
`define CLK_PERIOD_NS    25
`define DELAY_STEP_NS    100000000
`define DIV_STEPS        5'd26

`endif

// ===== hw/ain_trip_pkg.sv
// ain_trip_pkg: types shared by the analog input trip block.
// assumes ain_trip_defines.svh for the numbers.
package ain_trip_pkg;

   // trip comparator mode
   typedef enum logic [1:0] {
      TRIP_OFF  = 2'b00,
      TRIP_LOW  = 2'b01,
      TRIP_HIGH = 2'b10
   } trip_type_t;

   // divider sequencer
   typedef enum logic {
      DIV_IDLE = 1'b0,
      DIV_RUN  = 1'b1
   } div_state_t;

   // software settings
   typedef struct packed {
      trip_type_t  ttype;
      logic [6:0]  level;
      logic [9:0]  delay;
      logic [6:0]  span;
      logic [6:0]  offset;
   } cfg_t;

endpackage : ain_trip_pkg

// ===== hw/ain_div.sv
// ain_div: serial restoring divider, one quotient bit per clock.
// assumes den is never zero while start is high.
`timescale 1ns/1ps
`include "ain_trip_defines.svh"

module ain_div
   import ain_trip_pkg::*;
(
   input  wire logic        pclk,    // system clock
   input  wire logic        presetn, // async reset, low
   input  wire logic        start,   // begin when idle
   input  wire logic [25:0] num,     // dividend
   input  wire logic [18:0] den,     // divisor
   output logic             busy,    // division running
   output logic             done,    // one-cycle result strobe
   output logic [25:0]      quot     // quotient
);

   div_state_t  st_r;
   logic [18:0] rem_r;
   logic [18:0] den_r;
   logic [25:0] num_r;
   logic [4:0]  cnt_r;
   logic [19:0] rem_sh;

   assign rem_sh = {rem_r, quot[25]};
   assign busy   = (st_r == DIV_RUN);

   // -----------------------------------------------------------------
   // sequencer and datapath
   // -----------------------------------------------------------------
   // quotient by restoring steps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r  <= DIV_IDLE;
         rem_r <= 19'h0;
         den_r <= 19'h0;
         num_r <= 26'h0;
         quot  <= 26'h0;
         cnt_r <= 5'h0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_r)
            DIV_IDLE: begin
               if (start) begin
                  rem_r <= 19'h0;
                  den_r <= den;
                  num_r <= num;
                  quot  <= num;
                  cnt_r <= `DIV_STEPS;
                  st_r  <= DIV_RUN;
               end
            end
            DIV_RUN: begin
               if (rem_sh >= {1'b0, den_r}) begin
                  rem_r <= 19'(rem_sh - {1'b0, den_r});
                  quot  <= {quot[24:0], 1'b1};
               end else begin
                  rem_r <= rem_sh[18:0];
                  quot  <= {quot[24:0], 1'b0};
               end
               cnt_r <= cnt_r - 5'd1;
               if (cnt_r == 5'd1) begin
                  st_r <= DIV_IDLE;
                  done <= 1'b1;
               end
            end
            default: st_r <= DIV_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic [45:0] lo_prod;
   logic [45:0] hi_prod;
   assign lo_prod = 46'(quot) * 46'(den_r);
   assign hi_prod = lo_prod + 46'(den_r);

   a_div_exact: assert property (
      @(posedge pclk) disable iff (!presetn)
      done |-> (lo_prod <= 46'(num_r)) && (46'(num_r) < hi_prod))
      else $error("divider quotient is not exact");

   a_div_length: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_r == DIV_IDLE) && start |-> ##27 done)
      else $error("divider result not 27 cycles after start");

endmodule : ain_div

// ===== hw/analog_input_scale_trip.sv
// analog_input_scale_trip: scales one raw analog input to 0..100 percent
// and runs a low or high trip comparator with a persistence delay.
// assumes raw_in and motor_run are synchronous to pclk and an apb master.
`timescale 1ns/1ps
`include "ain_trip_defines.svh"

module analog_input_scale_trip
   import ain_trip_pkg::*;
#(
   parameter int unsigned TICK_CYC = `DELAY_STEP_NS / `CLK_PERIOD_NS
)(
   input  wire logic        pclk,       // system clock, 40 MHz
   input  wire logic        presetn,    // async reset, low
   input  wire logic [11:0] paddr,      // apb byte address
   input  wire logic        psel,       // apb select
   input  wire logic        penable,    // apb access phase
   input  wire logic        pwrite,     // apb direction
   input  wire logic [31:0] pwdata,     // apb write data
   output logic      [31:0] prdata,     // apb read data
   output logic             pready,     // apb ready
   output logic             pslverr,    // apb error
   input  wire logic [11:0] raw_in,     // raw code, 4095 full scale
   input  wire logic        motor_run,  // motor running
   output logic             irq,        // level interrupt
   output logic             trip_fault, // trip declared, sticky
   output logic      [6:0]  reading     // scaled percent
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   cfg_t        cfg_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;
   logic        pready_r;
   logic        pslverr_r;
   logic        hit_nxt;
   logic        wr_en;
   logic [1:0]  sts_r;
   logic [1:0]  sts_nxt;
   logic [1:0]  en_r;
   logic        irq_r;
   logic [6:0]  reading_r;
   logic        cond_r;
   logic        cond_nxt;
   logic        tripped_r;
   logic [21:0] pre_r;
   logic [9:0]  tcnt_r;
   logic        ev_trip;
   logic        ev_onset;
   logic [18:0] raw_x100;
   logic [18:0] lvl_fs;
   logic [18:0] off_fs;
   logic [18:0] diff;
   logic [25:0] div_num;
   logic [18:0] div_den;
   logic        div_busy;
   logic        div_done;
   logic [25:0] div_q;

   assign prdata     = prdata_r;
   assign pready     = pready_r;
   assign pslverr    = pslverr_r;
   assign irq        = irq_r;
   assign trip_fault = sts_r[`STS_TRIP];
   assign reading    = reading_r;

   // -----------------------------------------------------------------
   // apb slave: answer in the cycle after setup
   // -----------------------------------------------------------------
   // write takes effect at the edge that completes the access
   assign wr_en = psel && penable && pready_r && pwrite;

   // read mux and address decode
   always_comb begin
      rd_nxt  = 32'h0;
      hit_nxt = 1'b1;
      case (paddr)
         `ADDR_TRIP_TYPE:  rd_nxt[1:0] = cfg_r.ttype;
         `ADDR_TRIP_LEVEL: rd_nxt[6:0] = cfg_r.level;
         `ADDR_TRIP_DELAY: rd_nxt[9:0] = cfg_r.delay;
         `ADDR_SPAN:       rd_nxt[6:0] = cfg_r.span;
         `ADDR_OFFSET:     rd_nxt[6:0] = cfg_r.offset;
         `ADDR_READING:    rd_nxt[6:0] = reading_r;
         `ADDR_LIVE: begin
            rd_nxt[0]     = cond_r;
            rd_nxt[1]     = tripped_r;
            rd_nxt[2]     = motor_run;
            rd_nxt[27:16] = raw_in;
         end
         `ADDR_INT_STATUS: rd_nxt[1:0] = sts_r;
         `ADDR_INT_CLEAR:  rd_nxt      = 32'h0;
         `ADDR_INT_ENABLE: rd_nxt[1:0] = en_r;
         default:          hit_nxt     = 1'b0;
      endcase
   end

   // handshake and read data, captured at the end of setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end else begin
         pready_r  <= psel && !penable && !pready_r;
         pslverr_r <= psel && !penable && !pready_r && !hit_nxt;
         if (psel && !penable && !pwrite)
            prdata_r <= rd_nxt;
         else if (pready_r)
            prdata_r <= 32'h0;
      end
   end

   // -----------------------------------------------------------------
   // settings, written values held inside their ranges
   // -----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r.ttype  <= TRIP_OFF;
         cfg_r.level  <= `LEVEL_RST;
         cfg_r.delay  <= `DELAY_RST;
         cfg_r.span   <= `SPAN_RST;
         cfg_r.offset <= `OFFSET_RST;
         en_r         <= 2'h0;
      end else if (wr_en) begin
         case (paddr)
            `ADDR_TRIP_TYPE: begin
               if (pwdata[1:0] == 2'b11)
                  cfg_r.ttype <= TRIP_OFF;
               else
                  cfg_r.ttype <= trip_type_t'(pwdata[1:0]);
            end
            `ADDR_TRIP_LEVEL: begin
               if (pwdata[31:0] > 32'(`LEVEL_MAX))
                  cfg_r.level <= `LEVEL_MAX;
               else
                  cfg_r.level <= pwdata[6:0];
            end
            // delay held in 0.1 s steps
            `ADDR_TRIP_DELAY: begin
               if (pwdata[31:0] > 32'(`DELAY_MAX))
                  cfg_r.delay <= `DELAY_MAX;
               else if (pwdata[31:0] < 32'(`DELAY_MIN))
                  cfg_r.delay <= `DELAY_MIN;
               else
                  cfg_r.delay <= pwdata[9:0];
            end
            `ADDR_SPAN: begin
               if (pwdata[31:0] > 32'(`SPAN_MAX))
                  cfg_r.span <= `SPAN_MAX;
               else if (pwdata[31:0] < 32'(`SPAN_MIN))
                  cfg_r.span <= `SPAN_MIN;
               else
                  cfg_r.span <= pwdata[6:0];
            end
            `ADDR_OFFSET: begin
               if (pwdata[31:0] > 32'(`OFFSET_MAX))
                  cfg_r.offset <= `OFFSET_MAX;
               else
                  cfg_r.offset <= pwdata[6:0];
            end
            `ADDR_INT_ENABLE: en_r <= pwdata[1:0];
            default: ;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // trip comparator on the raw input
   // -----------------------------------------------------------------
   // both sides in percent times full-scale code
   assign raw_x100 = 19'(raw_in) * 19'(`PCT_FULL);
   assign lvl_fs   = 19'(cfg_r.level) * 19'(`FS_CODE);

   always_comb begin
      cond_nxt = 1'b0;
      if (motor_run) begin
         case (cfg_r.ttype)
            TRIP_LOW:  cond_nxt = raw_x100 < lvl_fs;
            TRIP_HIGH: cond_nxt = raw_x100 > lvl_fs;
            default:   cond_nxt = 1'b0;
         endcase
      end
   end

   // condition register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cond_r <= 1'b0;
      else
         cond_r <= cond_nxt;
   end

   // -----------------------------------------------------------------
   // persistence timer, restarts whenever the condition drops
   // -----------------------------------------------------------------
   // count whole 0.1 s steps of unbroken condition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r  <= 22'h0;
         tcnt_r <= 10'h0;
      end else if (!cond_r) begin
         pre_r  <= 22'h0;
         tcnt_r <= 10'h0;
      end else if (tcnt_r < cfg_r.delay) begin
         if (pre_r == 22'(TICK_CYC - 1)) begin
            pre_r  <= 22'h0;
            tcnt_r <= tcnt_r + 10'd1;
         end else begin
            pre_r <= pre_r + 22'd1;
         end
      end
   end

   assign ev_trip  = cond_r && !tripped_r && (tcnt_r >= cfg_r.delay);
   assign ev_onset = cond_nxt && !cond_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tripped_r <= 1'b0;
      else if (!cond_r)
         tripped_r <= 1'b0;
      else if (ev_trip)
         tripped_r <= 1'b1;
   end

   // -----------------------------------------------------------------
   // sticky status, clear register, interrupt
   // -----------------------------------------------------------------
   // set wins over a clear in the same cycle
   always_comb begin
      sts_nxt = sts_r;
      if (wr_en && (paddr == `ADDR_INT_CLEAR))
         sts_nxt = sts_r & ~pwdata[1:0];
      if (ev_trip)
         sts_nxt[`STS_TRIP] = 1'b1;
      if (ev_onset)
         sts_nxt[`STS_ONSET] = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_r <= 2'h0;
         irq_r <= 1'b0;
      end else begin
         sts_r <= sts_nxt;
         irq_r <= |(sts_nxt & en_r);
      end
   end

   // -----------------------------------------------------------------
   // scaling: (raw pct - offset) * 100 / span
   // -----------------------------------------------------------------
   // input at the offset gives zero
   assign off_fs = 19'(cfg_r.offset) * 19'(`FS_CODE);
   // below offset feeds a zero dividend
   assign diff   = (raw_x100 > off_fs) ? 19'(raw_x100 - off_fs) : 19'h0;
   // numerator and denominator share the full-scale unit
   assign div_num = 26'(diff) * 26'(`PCT_FULL);
   assign div_den = 19'(cfg_r.span) * 19'(`FS_CODE);

   ain_div u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (!div_busy),
      .num     (div_num),
      .den     (div_den),
      .busy    (div_busy),
      .done    (div_done),
      .quot    (div_q)
   );

   // clamp the quotient at full reading
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         reading_r <= 7'h0;
      else if (div_done)
         reading_r <= (div_q > 26'(`PCT_FULL)) ? `PCT_FULL : div_q[6:0];
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_type_off_idle: assert property (
      cfg_r.ttype == TRIP_OFF |=> !cond_r)
      else $error("condition seen with trip type off");

   a_motor_stopped: assert property (
      !motor_run |-> !ev_onset ##1 !cond_r)
      else $error("condition seen with motor stopped");

   a_low_compare: assert property (
      motor_run && cfg_r.ttype == TRIP_LOW |=> cond_r == ($past(raw_in)
         * 32'd100 < $past(cfg_r.level) * 32'd4095))
      else $error("low comparator wrong");

   a_high_compare: assert property (
      motor_run && cfg_r.ttype == TRIP_HIGH |=> cond_r == ($past(raw_in)
         * 32'd100 > $past(cfg_r.level) * 32'd4095))
      else $error("high comparator wrong");

   a_trip_delay: assert property (
      $rose(tripped_r) |-> $past(cond_r) &&
         ($past(tcnt_r) >= $past(cfg_r.delay)))
      else $error("trip declared before the delay");

   a_tick_pace: assert property (
      cond_r && $past(cond_r) && tcnt_r != $past(tcnt_r) |->
         $past(pre_r) == 22'(TICK_CYC - 1))
      else $error("delay step taken early");

   a_level_range: assert property (
      cfg_r.level <= `LEVEL_MAX)
      else $error("trip level out of range");

   a_set_ranges: assert property (
      cfg_r.span >= `SPAN_MIN && cfg_r.span <= `SPAN_MAX &&
         cfg_r.offset <= `OFFSET_MAX)
      else $error("span or offset out of range");

   a_read_ceiling: assert property (
      reading_r <= `PCT_FULL)
      else $error("reading above full");

   a_read_floor: assert property (
      div_done && $past(raw_x100, 27) <= $past(off_fs, 27) |=>
         reading_r == 7'h0)
      else $error("reading not zero at or below offset");

   a_irq_level: assert property (
      ev_trip && en_r[`STS_TRIP] |=> irq && trip_fault)
      else $error("trip did not raise interrupt");

   c_trip_seen: cover property (ev_trip);
   c_irq_seen: cover property ($rose(irq));
   c_read_full: cover property (div_done && div_q >= 26'd100);
   c_read_zero: cover property (cond_r && reading_r == 7'h0);

endmodule : analog_input_scale_trip

// ===== tb/ain_source.sv
// ain_source: analog source model, 0-10 v or 4-20 ma loop.
// assumes the bench commands level, run state and loop break.
`timescale 1ns/1ps

module ain_source (
   input  wire logic        pclk,     // system clock
   input  wire logic [11:0] code_cmd, // commanded level
   input  wire logic        run_cmd,  // motor running
   input  wire logic        open_cmd, // loop broken
   output logic      [11:0] raw_in,   // raw code to block
   output logic             motor_run // run state
);
   // a broken loop carries no current, so the code drops to zero
   always_ff @(posedge pclk) begin
      raw_in    <= open_cmd ? 12'h000 : code_cmd;
      motor_run <= run_cmd;
   end
endmodule : ain_source

// ===== tb/test_analog_input_scale_trip.sv
// test_analog_input_scale_trip: apb bench for scaling and trip.
// assumes ain_source on the analog side; TICK_CYC cut to 20.
`timescale 1ns/1ps
`include "ain_trip_defines.svh"

module test_analog_input_scale_trip
   import ain_trip_pkg::*;
;
   localparam int TICK = 20;
   localparam int FS   = `FS_CODE;
   localparam int PF   = `PCT_FULL;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr, code_cmd, raw_in;
   logic [31:0] pwdata, prdata, rd;
   logic        irq, trip_fault, run_cmd, open_cmd, motor_run, perr;
   logic [6:0]  reading;
   int          fail_count, comparisons;
   // reset values, then written value and value read back
   logic [11:0] ra [6] = '{`ADDR_TRIP_TYPE, `ADDR_TRIP_LEVEL,
      `ADDR_TRIP_DELAY, `ADDR_SPAN, `ADDR_OFFSET, `ADDR_INT_ENABLE};
   logic [31:0] rv [6] = '{0, `LEVEL_RST, `DELAY_RST, `SPAN_RST,
      `OFFSET_RST, 0};
   logic [11:0] ca [6] = '{`ADDR_TRIP_LEVEL, `ADDR_SPAN,
      `ADDR_TRIP_DELAY, `ADDR_TRIP_DELAY, `ADDR_OFFSET, `ADDR_TRIP_TYPE};
   int          cw [6] = '{200, 0, 0, 1000, 120, 3};
   int          ce [6] = '{100, 1, 1, 900, 99, 0};
   // span, offset, raw code
   int          sc [9][3] = '{'{100,0,0}, '{100,0,4095}, '{100,20,819},
      '{100,20,4095}, '{50,0,2048}, '{50,0,4095}, '{80,20,0},
      '{80,20,819}, '{80,20,4095}};

   analog_input_scale_trip #(.TICK_CYC(TICK)) dut_u (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .raw_in(raw_in), .motor_run(motor_run), .irq(irq),
      .trip_fault(trip_fault), .reading(reading));

   ain_source src_u (.pclk(pclk), .code_cmd(code_cmd),
      .run_cmd(run_cmd), .open_cmd(open_cmd), .raw_in(raw_in),
      .motor_run(motor_run));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic chk(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask : chk

   task automatic ctrip(input string w, input logic e);
      chk(w, {31'h0, e}, {31'h0, trip_fault});
   endtask : ctrip

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd      = prdata;
      perr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input string w, input logic [11:0] a,
                        input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(w, e, rd);
   endtask : rdchk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   task automatic wait_trip(input int lim);
      int n;
      n = 0;
      while (trip_fault !== 1'b1 && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_trip

   // expected reading, clamped to 0..100
   function automatic logic [31:0] pct(input int r, input int s,
                                       input int o);
      int v;
      v = r * PF - o * FS;
      if (v < 0) v = 0;
      v = v * PF / (s * FS);
      return (v > PF) ? PF : v;
   endfunction : pct

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // ---------------------------------------------
   // clock, watchdog, tests
   // ---------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   initial begin
      cyc(6000);
      fail_count++;
      print_verdict();
   end

   initial begin
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0;
      code_cmd = 12'h000;
      run_cmd  = 1'b0;
      open_cmd = 1'b0;
      cyc(8);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++) rdchk("reset", ra[i], rv[i]);
      chk("mapped err", 32'h0, {31'h0, perr});
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, ca[i], 32'(cw[i]));
         rdchk("clamp", ca[i], 32'(ce[i]));
      end
      apb(1'b0, 12'h0fc, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, perr});
      $display("test registers done");
      for (int i = 0; i < 9; i++) begin
         apb(1'b1, `ADDR_SPAN, 32'(sc[i][0]));
         apb(1'b1, `ADDR_OFFSET, 32'(sc[i][1]));
         code_cmd <= 12'(sc[i][2]);
         cyc(60);
         rdchk("reading", `ADDR_READING, pct(sc[i][2], sc[i][0],
               sc[i][1]));
         chk("reading port", pct(sc[i][2], sc[i][0], sc[i][1]),
             {25'h0, reading});
      end
      $display("test scaling done");
      apb(1'b1, `ADDR_TRIP_LEVEL, 32'hf);
      apb(1'b1, `ADDR_TRIP_DELAY, 32'h2);
      apb(1'b1, `ADDR_INT_ENABLE, 32'h1);
      apb(1'b1, `ADDR_TRIP_TYPE, {30'h0, TRIP_LOW});
      code_cmd <= 12'h2bc;
      run_cmd  <= 1'b1;
      cyc(60);
      ctrip("raw not scaled", 1'b0);
      open_cmd <= 1'b1;
      cyc(30);
      ctrip("trip early", 1'b0);
      open_cmd <= 1'b0;
      cyc(3);
      open_cmd <= 1'b1;
      cyc(30);
      ctrip("trip restart", 1'b0);
      wait_trip(40);
      ctrip("trip low", 1'b1);
      cyc(2);
      chk("irq set", 32'h1, {31'h0, irq});
      rdchk("status", `ADDR_INT_STATUS, 32'h3);
      rdchk("live", `ADDR_LIVE, 32'h7);
      open_cmd <= 1'b0;
      apb(1'b1, `ADDR_INT_CLEAR, 32'h3);
      rdchk("status clr", `ADDR_INT_STATUS, 32'h0);
      chk("irq clr", 32'h0, {31'h0, irq});
      ctrip("trip clr", 1'b0);
      $display("test low trip done");
      // high type, irq masked then enabled
      apb(1'b1, `ADDR_INT_ENABLE, 32'h0);
      apb(1'b1, `ADDR_TRIP_LEVEL, 32'h5a);
      apb(1'b1, `ADDR_TRIP_TYPE, {30'h0, TRIP_HIGH});
      code_cmd <= 12'hed8;
      wait_trip(70);
      ctrip("trip high", 1'b1);
      chk("irq masked", 32'h0, {31'h0, irq});
      apb(1'b1, `ADDR_INT_ENABLE, 32'h1);
      cyc(2);
      chk("irq enabled", 32'h1, {31'h0, irq});
      code_cmd <= 12'h2bc;
      apb(1'b1, `ADDR_INT_CLEAR, 32'h3);
      $display("test high trip done");
      apb(1'b1, `ADDR_TRIP_TYPE, {30'h0, TRIP_OFF});
      code_cmd <= 12'hed8;
      cyc(80);
      ctrip("type off", 1'b0);
      run_cmd <= 1'b0;
      apb(1'b1, `ADDR_TRIP_TYPE, {30'h0, TRIP_HIGH});
      cyc(80);
      ctrip("motor stopped", 1'b0);
      run_cmd <= 1'b1;
      wait_trip(70);
      ctrip("motor running", 1'b1);
      $display("test gating done");
      // mid-run reset drops the latched trip and settings
      presetn <= 1'b0;
      cyc(2);
      presetn <= 1'b1;
      ctrip("reset trip", 1'b0);
      rdchk("reset type", `ADDR_TRIP_TYPE, 32'h0);
      $display("test reset done");
      print_verdict();
   end
endmodule : test_analog_input_scale_trip
